// ---- logic/sps_pkg.sv ----
`default_nettype none

package sps_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFS_IRQ_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_DATA               = 8'h04;
  localparam logic [7:0] OFS_RX_DATA            = 8'h08;
  localparam logic [7:0] OFS_CONFIG             = 8'h0C;
  localparam logic [7:0] OFS_QUANTITY           = 8'h10;

  // ****************************************
  // status and control bit positions
  // ****************************************
  localparam int BIT_RX_HOLDING_IRQ_EN = 0;
  localparam int BIT_TX_SHIFTER_IRQ_EN = 1;
  localparam int BIT_TX_HOLDING_IRQ_EN = 2;
  localparam int BIT_RX_HOLDING_FULL   = 3;
  localparam int BIT_TX_SHIFTER_EMPTY  = 4;
  localparam int BIT_TX_HOLDING_EMPTY  = 5;
  localparam int BIT_RX_IDLE_IRQ_EN    = 6;
  localparam int BIT_RX_IDLE_EXPIRED   = 7;
  localparam int BIT_RX_QUEUE_EMPTY    = 8;
  localparam int BIT_RX_QUEUE_FULL     = 9;
  localparam int BIT_TX_QUEUE_EMPTY    = 10;
  localparam int BIT_TX_QUEUE_FULL     = 11;
  localparam int BIT_RX_QUEUE_OVERRUN  = 12;

  // config register fields
  localparam int BIT_CFG_TX_QUEUE_EN = 0;
  localparam int BIT_CFG_RX_QUEUE_EN = 1;
  localparam int BIT_CFG_ASYNC       = 2;
  localparam int POS_CFG_TX_THR      = 4;
  localparam int POS_CFG_RX_THR      = 6;

  // quantity register fields
  localparam int POS_QTY_TX = 10;
  localparam int POS_QTY_RX = 2;

  // ****************************************
  // sizes, counts and reset values
  // ****************************************
  localparam logic [4:0] QUEUE_DEPTH       = 5'h10;
  localparam int         IDLE_BYTES        = 4;
  localparam int         LINK_BITS_PER_BYTE = 10;
  localparam logic [5:0] IDLE_LINK_EDGES   = 6'(IDLE_BYTES * LINK_BITS_PER_BYTE);
  localparam logic [1:0] RST_TX_THR        = 2'h3;
  localparam logic [1:0] RST_RX_THR        = 2'h3;
  localparam logic       RST_ASYNC         = 1'b1;

  typedef struct packed {
    logic [1:0]  sin_sync;
    logic        sin_prev;
    logic [1:0]  sclk_sync;
    logic        sclk_prev;
    logic        tx_queue_en;
    logic        rx_queue_en;
    logic        asynchronous_mode;
    logic [1:0]  tx_thr;
    logic [1:0]  rx_thr;
    logic        rx_idle_irq_en;
    logic        tx_holding_irq_en;
    logic        tx_shifter_irq_en;
    logic        rx_holding_irq_en;
    logic        tx_holding_empty;
    logic        tx_shifter_empty;
    logic        rx_holding_full;
    logic        rx_queue_overrun;
    logic        rx_idle_expired;
    logic [4:0]  tx_cnt;
    logic [4:0]  rx_cnt;
    logic [5:0]  idle_cnt;
    logic [15:0] rdata;
    logic [7:0]  tx_push_data;
    logic        tx_push;
    logic        tx_load;
    logic        rx_pop;
    logic        irq;
  } sps_state_t;

endpackage

`default_nettype wire

// ---- logic/sps_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module sps_top (
  input  wire logic        CLK_SYS,
  input  wire logic        ARST_N,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output var  logic [15:0] REG_RDATA,
  input  wire logic [7:0]  RX_HEAD_DATA,
  input  wire logic        TX_LAST_BIT,
  input  wire logic        RX_CHAR_DONE,
  input  wire logic        SERIAL_IN_PIN,
  input  wire logic        SERIAL_CLK,
  output var  logic        TX_PUSH,
  output var  logic [7:0]  TX_PUSH_DATA,
  output var  logic        TX_SHIFT_LOAD,
  output var  logic        RX_POP,
  output var  logic        SERIAL_PORT_IRQ
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [4:0] tx_low_level(input logic [1:0] sel);
    logic [4:0] lvl;
    lvl = 5'h02;
    case (sel)
      2'h0: lvl = 5'h0C;
      2'h1: lvl = 5'h08;
      2'h2: lvl = 5'h04;
      default: lvl = 5'h02;
    endcase
    return lvl;
  endfunction

  function automatic logic [4:0] rx_high_level(input logic [1:0] sel);
    logic [4:0] lvl;
    lvl = 5'h0E;
    case (sel)
      2'h0: lvl = 5'h04;
      2'h1: lvl = 5'h08;
      2'h2: lvl = 5'h0C;
      default: lvl = 5'h0E;
    endcase
    return lvl;
  endfunction

  function automatic logic tx_full(input sps_pkg::sps_state_t s);
    return s.tx_queue_en ? (s.tx_cnt == sps_pkg::QUEUE_DEPTH) : !s.tx_holding_empty;
  endfunction

  function automatic logic rx_full(input sps_pkg::sps_state_t s);
    return s.rx_queue_en ? (s.rx_cnt == sps_pkg::QUEUE_DEPTH) : s.rx_holding_full;
  endfunction

  function automatic logic rx_avail(input sps_pkg::sps_state_t s);
    return s.rx_queue_en ? (s.rx_cnt != 5'h00) : s.rx_holding_full;
  endfunction

  // status word as software sees it
  function automatic logic [15:0] status_word(input sps_pkg::sps_state_t s);
    logic [15:0] w;
    w = 16'h0000;
    w[sps_pkg::BIT_RX_QUEUE_OVERRUN]  = s.rx_queue_overrun;
    w[sps_pkg::BIT_TX_QUEUE_FULL]     = tx_full(s);
    w[sps_pkg::BIT_TX_QUEUE_EMPTY]    = s.tx_queue_en ? (s.tx_cnt == 5'h00)
                                                      : s.tx_holding_empty;
    w[sps_pkg::BIT_RX_QUEUE_FULL]     = rx_full(s);
    w[sps_pkg::BIT_RX_QUEUE_EMPTY]    = !rx_avail(s);
    w[sps_pkg::BIT_RX_IDLE_EXPIRED]   = s.rx_idle_expired;
    w[sps_pkg::BIT_RX_IDLE_IRQ_EN]    = s.rx_idle_irq_en;
    w[sps_pkg::BIT_TX_HOLDING_EMPTY]  = s.tx_queue_en
                                        ? (s.tx_cnt <= tx_low_level(s.tx_thr))
                                        : s.tx_holding_empty;
    w[sps_pkg::BIT_TX_SHIFTER_EMPTY]  = s.tx_shifter_empty;
    // meaningless in synchronous mode, so it reads as zero there
    w[sps_pkg::BIT_RX_HOLDING_FULL]   = s.asynchronous_mode &&
                                        (s.rx_queue_en
                                         ? (s.rx_cnt >= rx_high_level(s.rx_thr))
                                         : s.rx_holding_full);
    w[sps_pkg::BIT_TX_HOLDING_IRQ_EN] = s.tx_holding_irq_en;
    w[sps_pkg::BIT_TX_SHIFTER_IRQ_EN] = s.tx_shifter_irq_en;
    w[sps_pkg::BIT_RX_HOLDING_IRQ_EN] = s.rx_holding_irq_en;
    return w;
  endfunction

  function automatic logic port_irq(input sps_pkg::sps_state_t s);
    logic [15:0] w;
    w = status_word(s);
    return (w[sps_pkg::BIT_TX_HOLDING_EMPTY] && s.tx_holding_irq_en)
         | (w[sps_pkg::BIT_TX_SHIFTER_EMPTY] && s.tx_shifter_irq_en)
         | (w[sps_pkg::BIT_RX_HOLDING_FULL]  && s.rx_holding_irq_en)
         | (w[sps_pkg::BIT_RX_IDLE_EXPIRED]  && s.rx_idle_irq_en);
  endfunction

  // ****************************************
  // state
  // ****************************************
  sps_pkg::sps_state_t s_q;
  sps_pkg::sps_state_t s_d;

  logic wr_status;
  logic wr_data;
  logic wr_rx;
  logic wr_cfg;
  logic rd_status;
  logic rd_data;
  logic rd_rx;
  logic start_edge;
  logic link_edge;
  logic idle_ok;
  logic tx_avail;

  always_comb begin
    wr_status = 1'b0;
    wr_data   = 1'b0;
    wr_rx     = 1'b0;
    wr_cfg    = 1'b0;
    rd_status = 1'b0;
    rd_data   = 1'b0;
    rd_rx     = 1'b0;
    if (REG_ADDR == sps_pkg::OFS_IRQ_STATUS_CONTROL) begin
      wr_status = REG_WR;
      rd_status = REG_RD;
    end else if (REG_ADDR == sps_pkg::OFS_DATA) begin
      wr_data = REG_WR;
      rd_data = REG_RD;
    end else if (REG_ADDR == sps_pkg::OFS_RX_DATA) begin
      wr_rx = REG_WR;
      rd_rx = REG_RD;
    end else if (REG_ADDR == sps_pkg::OFS_CONFIG) begin
      wr_cfg = REG_WR;
    end

    s_d = s_q;

    // ****************************************
    // pin synchronisers
    // ****************************************
    s_d.sin_sync  = {s_q.sin_sync[0], SERIAL_IN_PIN};
    s_d.sin_prev  = s_q.sin_sync[1];
    s_d.sclk_sync = {s_q.sclk_sync[0], SERIAL_CLK};
    s_d.sclk_prev = s_q.sclk_sync[1];
    start_edge    = s_q.sin_prev && !s_q.sin_sync[1];
    link_edge     = !s_q.sclk_prev && s_q.sclk_sync[1];

    // ****************************************
    // control writes
    // ****************************************
    if (wr_status) begin
      s_d.rx_idle_irq_en    = REG_WDATA[sps_pkg::BIT_RX_IDLE_IRQ_EN];
      s_d.tx_holding_irq_en = REG_WDATA[sps_pkg::BIT_TX_HOLDING_IRQ_EN];
      s_d.tx_shifter_irq_en = REG_WDATA[sps_pkg::BIT_TX_SHIFTER_IRQ_EN];
      s_d.rx_holding_irq_en = REG_WDATA[sps_pkg::BIT_RX_HOLDING_IRQ_EN];
    end
    if (wr_cfg) begin
      s_d.tx_queue_en       = REG_WDATA[sps_pkg::BIT_CFG_TX_QUEUE_EN];
      s_d.rx_queue_en       = REG_WDATA[sps_pkg::BIT_CFG_RX_QUEUE_EN];
      s_d.asynchronous_mode = REG_WDATA[sps_pkg::BIT_CFG_ASYNC];
      s_d.tx_thr            = REG_WDATA[sps_pkg::POS_CFG_TX_THR +: 2];
      s_d.rx_thr            = REG_WDATA[sps_pkg::POS_CFG_RX_THR +: 2];
    end

    // ****************************************
    // transmit side
    // ****************************************
    s_d.tx_push      = 1'b0;
    s_d.tx_load      = 1'b0;
    s_d.tx_push_data = s_q.tx_push_data;
    if (TX_LAST_BIT) begin
      s_d.tx_shifter_empty = 1'b1;
    end
    // a write into a full holding stage or queue is dropped
    if (wr_data && !tx_full(s_q)) begin
      s_d.tx_push      = 1'b1;
      s_d.tx_push_data = REG_WDATA[7:0];
      if (s_q.tx_queue_en) begin
        s_d.tx_cnt = s_q.tx_cnt + 5'h01;
      end else begin
        s_d.tx_holding_empty = 1'b0;
      end
    end
    tx_avail = s_d.tx_queue_en ? (s_d.tx_cnt != 5'h00) : !s_d.tx_holding_empty;
    // an idle shifter pulls the next byte at once, so a write into an
    // idle path leaves the holding stage empty and only the shifter busy
    if (s_d.tx_shifter_empty && tx_avail) begin
      s_d.tx_load          = 1'b1;
      s_d.tx_shifter_empty = 1'b0;
      if (s_d.tx_queue_en) begin
        s_d.tx_cnt = s_d.tx_cnt - 5'h01;
      end else begin
        s_d.tx_holding_empty = 1'b1;
      end
    end

    // ****************************************
    // receive side
    // ****************************************
    s_d.rx_pop = 1'b0;
    if (rd_status) begin
      s_d.rx_queue_overrun = 1'b0;
    end
    if (rd_data && rx_avail(s_q)) begin
      s_d.rx_pop = 1'b1;
      if (s_q.rx_queue_en) begin
        s_d.rx_cnt = s_q.rx_cnt - 5'h01;
      end else begin
        s_d.rx_holding_full = 1'b0;
      end
    end
    // arrival after the pop, so a byte landing on a read is kept
    if (RX_CHAR_DONE) begin
      if (rx_full(s_q) && !s_d.rx_pop) begin
        s_d.rx_queue_overrun = 1'b1;
      end else if (s_d.rx_queue_en) begin
        s_d.rx_cnt = s_d.rx_cnt + 5'h01;
      end else begin
        s_d.rx_holding_full = 1'b1;
      end
    end

    // ****************************************
    // receive idle timer
    // ****************************************
    // counts link clock edges as bit times; the count only means byte
    // times while the peer keeps the link clock running
    if (wr_rx) begin
      s_d.rx_idle_expired = 1'b0;
    end
    idle_ok = !rx_full(s_q) && !start_edge && !rd_data && !rd_rx && !wr_rx;
    if (!idle_ok) begin
      s_d.idle_cnt = 6'h00;
    end else if (link_edge && (s_q.idle_cnt != sps_pkg::IDLE_LINK_EDGES)) begin
      s_d.idle_cnt = s_q.idle_cnt + 6'h01;
    end
    if (idle_ok && (s_d.idle_cnt == sps_pkg::IDLE_LINK_EDGES)) begin
      s_d.rx_idle_expired = 1'b1;
    end

    // ****************************************
    // read data and interrupt
    // ****************************************
    s_d.rdata = 16'h0000;
    if (rd_status) begin
      s_d.rdata = status_word(s_q);
    end else if (rd_data || rd_rx) begin
      s_d.rdata = {8'h00, RX_HEAD_DATA};
    end else if (REG_RD && (REG_ADDR == sps_pkg::OFS_CONFIG)) begin
      s_d.rdata[sps_pkg::BIT_CFG_TX_QUEUE_EN]   = s_q.tx_queue_en;
      s_d.rdata[sps_pkg::BIT_CFG_RX_QUEUE_EN]   = s_q.rx_queue_en;
      s_d.rdata[sps_pkg::BIT_CFG_ASYNC]         = s_q.asynchronous_mode;
      s_d.rdata[sps_pkg::POS_CFG_TX_THR +: 2]   = s_q.tx_thr;
      s_d.rdata[sps_pkg::POS_CFG_RX_THR +: 2]   = s_q.rx_thr;
    end else if (REG_RD && (REG_ADDR == sps_pkg::OFS_QUANTITY)) begin
      s_d.rdata[sps_pkg::POS_QTY_TX +: 5] = s_q.tx_cnt;
      s_d.rdata[sps_pkg::POS_QTY_RX +: 5] = s_q.rx_cnt;
    end
    // built from the next state so it drops with its status or enable
    s_d.irq = port_irq(s_d);
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      s_q                   <= '0;
      s_q.asynchronous_mode <= sps_pkg::RST_ASYNC;
      s_q.tx_thr            <= sps_pkg::RST_TX_THR;
      s_q.rx_thr            <= sps_pkg::RST_RX_THR;
      s_q.tx_holding_empty  <= 1'b1;
      s_q.tx_shifter_empty  <= 1'b1;
      s_q.sin_sync          <= 2'h3;
      s_q.sin_prev          <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign REG_RDATA       = s_q.rdata;
  assign TX_PUSH         = s_q.tx_push;
  assign TX_PUSH_DATA    = s_q.tx_push_data;
  assign TX_SHIFT_LOAD   = s_q.tx_load;
  assign RX_POP          = s_q.rx_pop;
  assign SERIAL_PORT_IRQ = s_q.irq;

endmodule

`default_nettype wire

// ---- sim/sps_peer.sv ----
`timescale 1ns/1ps
`default_nettype none

// engines and line partner; shifting takes DLY cycles, held while stalled
module sps_peer #(
  parameter int         DLY   = 20,
  parameter logic [7:0] HEAD0 = 8'h5A
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       load,
  input  wire logic       pop,
  input  wire logic       stall,
  input  wire logic       char_req,
  output logic            last_bit,
  output logic            char_done,
  output logic            sin,
  output logic            sclk,
  output logic [7:0]      head
);
  int cnt;
  int rcnt;

  // async link clock runs free, unrelated in phase to the system clock
  initial begin
    sclk = 1'b0;
    #137;
    forever #400 sclk = ~sclk;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt       <= 0;
      rcnt      <= 0;
      last_bit  <= 1'b0;
      char_done <= 1'b0;
      sin       <= 1'b1;
      head      <= HEAD0;
    end else begin
      last_bit  <= cnt == 1 && !stall && !load;
      char_done <= rcnt == 1;
      if (load) cnt <= DLY;
      else if (cnt > 0 && !stall) cnt <= cnt - 1;
      if (char_req) rcnt <= 12;
      else if (rcnt > 0) rcnt <= rcnt - 1;
      // start bit is the low stretch; the line idles high
      sin <= !(rcnt > 2);
      if (pop) head <= head + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ---- sim/sps_properties.sv ----
`timescale 1ns/1ps
`default_nettype none

module sps_properties (
  input wire logic        CLK_SYS,
  input wire logic        ARST_N,
  input wire logic [7:0]  REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [15:0] REG_RDATA,
  input wire logic [7:0]  RX_HEAD_DATA,
  input wire logic        TX_LAST_BIT,
  input wire logic        RX_CHAR_DONE,
  input wire logic        SERIAL_IN_PIN,
  input wire logic        SERIAL_CLK,
  input wire logic        TX_PUSH,
  input wire logic [7:0]  TX_PUSH_DATA,
  input wire logic        TX_SHIFT_LOAD,
  input wire logic        RX_POP,
  input wire logic        SERIAL_PORT_IRQ
);
  logic [3:0] en_q;
  logic       async_q;
  logic       st_rd;
  logic       dat_wr;

  assign st_rd  = REG_RD && REG_ADDR == sps_pkg::OFS_IRQ_STATUS_CONTROL;
  assign dat_wr = REG_WR && REG_ADDR == sps_pkg::OFS_DATA;

  // enables and mode mirrored from the strobes only, never from the design
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      en_q    <= 4'h0;
      async_q <= sps_pkg::RST_ASYNC;
    end else if (REG_WR && REG_ADDR == sps_pkg::OFS_IRQ_STATUS_CONTROL) begin
      en_q <= {REG_WDATA[6], REG_WDATA[2:0]};
    end else if (REG_WR && REG_ADDR == sps_pkg::OFS_CONFIG) begin
      async_q <= REG_WDATA[2];
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);

  // ****************************************
  // properties
  // ****************************************
  property p_rdata_idle; !$past(REG_RD) |-> REG_RDATA == 16'h0000; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer cycle");
  property p_unmapped;
    REG_RD && !(REG_ADDR inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}) |=> REG_RDATA == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_en_read; st_rd |=> {REG_RDATA[6], REG_RDATA[2:0]} == en_q; endproperty
  a_en_read: assert property (p_en_read) else $error("enable bits wrong");
  property p_upper; st_rd |=> REG_RDATA[15:13] == 3'h0; endproperty
  a_upper: assert property (p_upper) else $error("unused status bits set");
  property p_irq_or;
    st_rd |=> $past(SERIAL_PORT_IRQ) == ((REG_RDATA[5] & REG_RDATA[2]) | (REG_RDATA[4] &
      REG_RDATA[1]) | (REG_RDATA[3] & REG_RDATA[0]) | (REG_RDATA[7] & REG_RDATA[6]));
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq not OR of sources");
  property p_irq_off; en_q == 4'h0 |-> !SERIAL_PORT_IRQ; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq with all enables off");
  property p_sync_rx; st_rd && !async_q |=> !REG_RDATA[3]; endproperty
  a_sync_rx: assert property (p_sync_rx) else $error("rx flag in sync mode");
  property p_push;
    TX_PUSH |-> $past(dat_wr) && {8'h00, TX_PUSH_DATA} == ($past(REG_WDATA) & 16'h00FF);
  endproperty
  a_push: assert property (p_push) else $error("push without data write");
  property p_load; TX_SHIFT_LOAD |-> $past(dat_wr) || $past(TX_LAST_BIT); endproperty
  a_load: assert property (p_load) else $error("shifter load without cause");
  property p_pop;
    RX_POP |-> $past(REG_RD) && $past(REG_ADDR) == sps_pkg::OFS_DATA;
  endproperty
  a_pop: assert property (p_pop) else $error("pop without data read");
endmodule

bind sps_top sps_properties i_props (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .RX_HEAD_DATA(RX_HEAD_DATA), .TX_LAST_BIT(TX_LAST_BIT), .RX_CHAR_DONE(RX_CHAR_DONE),
  .SERIAL_IN_PIN(SERIAL_IN_PIN), .SERIAL_CLK(SERIAL_CLK), .TX_PUSH(TX_PUSH),
  .TX_PUSH_DATA(TX_PUSH_DATA), .TX_SHIFT_LOAD(TX_SHIFT_LOAD), .RX_POP(RX_POP),
  .SERIAL_PORT_IRQ(SERIAL_PORT_IRQ));
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam int DLY = 20;
  logic clk, rst_n, wr_s, rd_s, last_bit, char_done, sin, sclk, push, load, pop, irq;
  logic stall, char_req;
  logic [7:0]  addr, head, pdata, hd;
  logic [15:0] wdata, rdata, d, w;
  int          i, n, cyc, error_cnt, samples_checked;

  sps_top i_dut (.CLK_SYS(clk), .ARST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata), .RX_HEAD_DATA(head),
    .TX_LAST_BIT(last_bit), .RX_CHAR_DONE(char_done), .SERIAL_IN_PIN(sin),
    .SERIAL_CLK(sclk), .TX_PUSH(push), .TX_PUSH_DATA(pdata), .TX_SHIFT_LOAD(load),
    .RX_POP(pop), .SERIAL_PORT_IRQ(irq));
  sps_peer #(.DLY(DLY), .HEAD0(8'h5A)) i_peer (.clk(clk), .rst_n(rst_n), .load(load),
    .pop(pop), .stall(stall), .char_req(char_req), .last_bit(last_bit),
    .char_done(char_done), .sin(sin), .sclk(sclk), .head(head));

  // ****************************************
  // bus tasks and checking
  // ****************************************
  task reg_wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    #1;
  endtask

  task reg_rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    v = rdata;
  endtask

  task rx_char();
    @(posedge clk);
    char_req <= 1'b1;
    @(posedge clk);
    char_req <= 1'b0;
    repeat (16) @(posedge clk);
  endtask

  task chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value at %0t ns: saw %h expected %h", $time, s, e);
    end
  endtask

  // status bits 12, 9, 8, 3 after k bytes reach the rx queue, high mark 4
  function logic [15:0] exp_rx(input int k);
    return {3'h0, k > 16, 2'h0, k >= 16, 5'h00, k >= 4, 3'h0};
  endfunction

  task summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    {rst_n, wr_s, rd_s, stall, char_req, addr, wdata, cyc, error_cnt, samples_checked} = '0;
    void'($urandom(32'hCB10B0D6));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    reg_rd(8'h00, d);
    chk(d, 16'h0530);
    reg_rd(8'h0C, d);
    chk(d, 16'h00F4);
    for (i = 0; i < 4; i++) begin
      hd = 8'h14 + 8'($urandom_range(200));
      reg_wr(hd, 16'hFFFF);
      reg_rd(hd, d);
      chk(d, 16'h0000);
      w = 16'($urandom());
      reg_wr(8'h00, w);
      reg_rd(8'h00, d);
      chk(d & 16'h0047, w & 16'h0047);
      chk({15'h0, irq}, {15'h0, w[2] | w[1]});
    end
    reg_wr(8'h00, 16'h0006);
    stall <= 1'b1;
    w = 16'($urandom());
    reg_wr(8'h04, w);
    chk({6'h00, load, push, pdata}, {8'h03, w[7:0]});
    reg_rd(8'h00, d);
    chk(d & 16'h0030, 16'h0020);
    chk({15'h0, irq}, 16'h0001);
    reg_wr(8'h04, 16'($urandom()));
    reg_rd(8'h00, d);
    chk(d & 16'h0030, 16'h0000);
    chk({15'h0, irq}, 16'h0000);
    stall <= 1'b0;
    repeat (DLY + 4) @(posedge clk);
    reg_rd(8'h00, d);
    chk(d & 16'h0030, 16'h0020);
    repeat (DLY + 4) @(posedge clk);
    reg_rd(8'h00, d);
    chk(d & 16'h0030, 16'h0030);
    reg_wr(8'h00, 16'h0001);
    rx_char();
    reg_rd(8'h00, d);
    chk(d & 16'h0008, 16'h0008);
    chk({15'h0, irq}, 16'h0001);
    reg_rd(8'h04, d);
    chk({7'h00, pop, d[7:0]}, {8'h01, 8'h5A});
    reg_rd(8'h00, d);
    chk({d[3], 14'h0, irq}, 16'h0000);
    reg_wr(8'h0C, 16'h00F0);
    rx_char();
    reg_rd(8'h00, d);
    chk({d[3], 14'h0, irq}, 16'h0000);
    reg_wr(8'h0C, 16'h00F4);
    reg_rd(8'h04, d);
    reg_wr(8'h0C, 16'h0036);
    reg_rd(8'h00, d);
    chk(d & 16'h0100, 16'h0100);
    for (i = 1; i <= 17; i++) begin
      rx_char();
      reg_rd(8'h00, d);
      chk(d & 16'h1308, exp_rx(i));
    end
    reg_rd(8'h10, d);
    chk(d & 16'h007C, 16'h0040);
    reg_rd(8'h00, d);
    chk(d & 16'h1000, 16'h0000);
    repeat (16) reg_rd(8'h04, d);
    reg_rd(8'h00, d);
    chk(d & 16'h0308, 16'h0100);
    reg_wr(8'h0C, 16'h0035);
    reg_rd(8'h0C, d);
    chk(d, 16'h0035);
    stall <= 1'b1;
    n = 0;
    do begin
      reg_wr(8'h04, 16'($urandom()));
      reg_rd(8'h00, d);
      n++;
    end while (d[11] !== 1'b1 && n < 20);
    reg_wr(8'h04, 16'($urandom()));
    chk({15'h0, push}, 16'h0000);
    reg_rd(8'h00, d);
    chk(d & 16'h0C30, 16'h0800);
    reg_rd(8'h10, d);
    chk(d & 16'h7C00, 16'h4000);
    stall <= 1'b0;
    repeat (17 * (DLY + 3)) @(posedge clk);
    reg_rd(8'h00, d);
    chk(d & 16'h0C30, 16'h0430);
    reg_wr(8'h08, 16'h0000);
    reg_wr(8'h00, 16'h0040);
    repeat (280) @(posedge clk);
    reg_rd(8'h00, d);
    chk(d & 16'h0080, 16'h0000);
    rx_char();
    // a byte left in the holding stage counts as full and would stall the timer
    reg_rd(8'h08, d);
    chk({7'h00, pop, d[7:0]}, 16'h006C);
    reg_rd(8'h04, d);
    chk({7'h00, pop, d[7:0]}, 16'h016C);
    repeat (280) @(posedge clk);
    reg_rd(8'h00, d);
    chk(d & 16'h0080, 16'h0000);
    repeat (80) @(posedge clk);
    reg_rd(8'h00, d);
    chk({d[7], 14'h0, irq}, 16'h8001);
    reg_wr(8'h08, 16'($urandom()));
    reg_rd(8'h00, d);
    chk({d[7], 14'h0, irq}, 16'h0000);
    summarize();
  end
endmodule
`default_nettype wire
